// ---- pkg/fdc_out_pkg.sv ----
// constants for the floppy drive output control block
// assumes an 8-bit host i/o bus with decoded address, read and write strobes
// Notes on behaviour
// - primary status-b reads ones in bits 7,6
// - alternate bit 2 latches write gate, read clears
// - alternate bit 3 latches read-data trailing edge
// - alternate bit 4 latches write-data edge, ungated
// - alternate bits 5,6 show drive select levels
// - output register always writable, survives soft reset
// - bits 1:0 binary drive number, one selected
// - bit 2 low holds controller in reset
// - soft reset at least 100ns, two writes suffice
// - mode a: bit 3 enables dma/irq pins
// - mode b: dma/irq pins always enabled
// - bits 4,5 drive active-low motor outputs
// - normal decode of selects and motors
// - swapped decode exchanges drives 0 and 1
// - tape bits 1:0 name tape drive
// - tape register survives soft reset, upper bits float except in enhanced mode 2
// - enhanced mode 2 read adds boot, type
// - drive type chosen from config byte pairs
// - digital input register read at 3f7
package fdc_out_pkg;
  localparam logic [15:0] ADDR_STATUS_B  = 16'h03f1;
  localparam logic [15:0] ADDR_OUT_CTRL  = 16'h03f2;
  localparam logic [15:0] ADDR_TAPE      = 16'h03f3;
  localparam logic [15:0] ADDR_DIG_IN    = 16'h03f7;
  localparam logic [7:0]  OUT_CTRL_RESET = 8'h00;
  localparam logic [1:0]  TAPE_RESET     = 2'h0;
  localparam logic [1:0]  BOOT_RESET     = 2'h0;
  localparam int          BIT_RST        = 2;
  localparam int          BIT_DMA        = 3;
  localparam int          BIT_MOT0       = 4;
  localparam int          BIT_MOT1       = 5;
  localparam int          CLK_NS         = 100;
  localparam int          SOFT_RST_MIN_NS = 100;
  localparam int          SOFT_RST_CYC   =
    ((SOFT_RST_MIN_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
    ((SOFT_RST_MIN_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [1:0] {
    MODE_COMPAT_A,
    MODE_COMPAT_B,
    MODE_ENHANCED2
  } floppy_mode_t;
endpackage

// ---- tb/drive_model.sv ----
// drive-side model: one-cycle activity pulses on the drive lines
// assumes pulse requests from the bench change just after a clk edge
`timescale 1ns/1ps
`default_nettype none
module drive_model (
  // clock
  input  wire logic       clk,
  // pulse requests
  input  wire logic [2:0] fire,
  // drive activity
  output var  logic       write_gate_out,
  output var  logic       read_data_in,
  output var  logic       write_data_out
);
  initial begin
    write_gate_out = 1'b0;
    read_data_in = 1'b0;
    write_data_out = 1'b0;
  end
  // each pulse rises and falls, so both edge senses are seen
  always @(posedge clk) begin
    write_gate_out <= fire[0];
    read_data_in <= fire[1];
    write_data_out <= fire[2];
  end
endmodule // drive_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the floppy drive output control block
// assumes the drive model of drive_model.sv and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fdc_out_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, io_rdata_oe, rd_d, rd_oe;
  floppy_mode_t mode = MODE_COMPAT_A;
  logic swap_drives = 1'b0;
  logic alt_status_b = 1'b0;
  logic [7:0] drive_type_config = 8'he4;
  logic [2:0] fire = 3'h0;
  logic wg, rdat, wdat, s0_n, s1_n, m0_n, m1_n, srst_n, dma_en, dir_rd;
  logic seen_rst = 1'b0;
  int num_errors = 0;
  int n_checks = 0;

  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (srst_n === 1'b0) begin
      seen_rst <= 1'b1;
    end
  end

  floppy_drive_output_control u_dut (.clk(clk), .nrst(nrst),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .mode(mode),
    .swap_drives(swap_drives), .alt_status_b(alt_status_b),
    .drive_type_config(drive_type_config), .write_gate_out(wg),
    .read_data_in(rdat), .write_data_out(wdat), .drive_number_bit0_n(s0_n),
    .drive_number_bit1_n(s1_n), .motor_on0_out(m0_n), .motor_on1_out(m1_n),
    .soft_rst_n(srst_n), .dma_pin_enable(dma_en), .dig_in_read(dir_rd));
  drive_model u_drive (.clk(clk), .fire(fire), .write_gate_out(wg),
    .read_data_in(rdat), .write_data_out(wdat));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    rd_d = io_rdata;
    rd_oe = io_rdata_oe;
  endtask
  // expected {sel1_n, sel0_n, mot1_n, mot0_n}
  function automatic logic [3:0] dec(input logic [7:0] c, input logic sw);
    logic a, b;
    a = (c[1:0] == 2'h0) && c[4];
    b = (c[1:0] == 2'h1) && c[5];
    if (sw) return {~a, ~b, ~c[4], ~c[5]};
    return {~b, ~a, ~c[5], ~c[4]};
  endfunction

  task automatic t_reset;
    rd(ADDR_OUT_CTRL);
    chk(rd_d, OUT_CTRL_RESET);
    chk({4'h0, s1_n, s0_n, m1_n, m0_n}, 8'h0f);
    chk({6'h0, srst_n, dma_en}, 8'h00);
    rd(16'h03f6);
    chk(rd_oe, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_decode;
    logic [7:0] tb_v [7] = '{8'h1c, 8'h2d, 8'h2c, 8'h1d, 8'hfe, 8'hff, 8'h30};
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      swap_drives <= s[0];
      foreach (tb_v[i]) begin
        wr(ADDR_OUT_CTRL, tb_v[i]);
        cyc(2);
        chk({4'h0, s1_n, s0_n, m1_n, m0_n}, {4'h0, dec(tb_v[i], s[0])});
        chk({6'h0, srst_n, dma_en}, {6'h0, tb_v[i][2], tb_v[i][3]});
        rd(ADDR_OUT_CTRL);
        chk(rd_d, tb_v[i]);
      end
    end
    @(posedge clk);
    swap_drives <= 1'b0;
    $display("test decode done");
  endtask
  task automatic t_tape;
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_TAPE, {6'h3f, t[1:0]});
      rd(ADDR_TAPE);
      chk(rd_d & 8'h03, {6'h0, t[1:0]});
      chk(rd_oe, 8'h03);
    end
    @(posedge clk);
    mode <= MODE_ENHANCED2;
    wr(ADDR_TAPE, 8'h0d);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_OUT_CTRL, {6'h07, k[1:0]});
      rd(ADDR_TAPE);
      chk(rd_d & 8'h3f, {2'h0, drive_type_config[2*k +: 2], 4'hd});
      chk(rd_oe & 8'h3f, 8'h3f);
    end
    @(posedge clk);
    mode <= MODE_COMPAT_A;
    $display("test tape done");
  endtask
  task automatic t_softrst;
    wr(ADDR_OUT_CTRL, 8'h1c);
    cyc(2);
    seen_rst = 1'b0;
    wr(ADDR_OUT_CTRL, 8'h18);
    wr(ADDR_OUT_CTRL, 8'h1c);
    cyc(3);
    chk({6'h0, seen_rst, srst_n}, 8'h03);
    rd(ADDR_OUT_CTRL);
    chk(rd_d, 8'h1c);
    rd(ADDR_TAPE);
    chk(rd_d & 8'h03, 8'h01);
    $display("test soft reset done");
  endtask
  task automatic t_status;
    rd(ADDR_STATUS_B);
    chk(rd_d & 8'hc0, 8'hc0);
    @(posedge clk);
    alt_status_b <= 1'b1;
    rd(ADDR_DIG_IN);
    chk({dir_rd, rd_oe[6:0]}, 8'h80);
    rd(ADDR_STATUS_B);
    chk(rd_d, 8'hc3);
    for (int f = 0; f < 3; f++) begin
      @(posedge clk);
      fire <= 3'h1 << f;
      @(posedge clk);
      fire <= 3'h0;
      cyc(4);
      rd(ADDR_STATUS_B);
      chk(rd_d, 8'hc3 | (8'h04 << f));
      rd(ADDR_DIG_IN);
      rd(ADDR_STATUS_B);
      chk(rd_d, 8'hc3);
    end
    $display("test status done");
  endtask
  task automatic t_modeb;
    @(posedge clk);
    mode <= MODE_COMPAT_B;
    nrst <= 1'b0;
    cyc(3);
    chk({7'h0, dma_en}, 8'h01);
    @(posedge clk);
    nrst <= 1'b1;
    cyc(2);
    chk({7'h0, dma_en}, 8'h01);
    rd(ADDR_OUT_CTRL);
    chk(rd_d, 8'h00);
    $display("test mode b done");
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    cyc(1);
    t_reset;
    t_decode;
    t_tape;
    t_softrst;
    t_status;
    t_modeb;
    close_out;
  end
  initial begin
    #(5000 * CLK_NS);
    num_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    close_out;
  end
endmodule // tb
`default_nettype wire

// ---- verilog/drive_decode.sv ----
// combinational drive select and motor decode, normal or swapped
// assumes the output control byte comes straight from its register
`timescale 1ns/1ps
`default_nettype none
module drive_decode (
  // control byte and order
  input  wire logic [7:0] ctrl,
  input  wire logic       swap,
  // active-low drive lines
  output logic            sel0_n,
  output logic            sel1_n,
  output logic            mot0_n,
  output logic            mot1_n
);
  logic pick0;
  logic pick1;

  assign pick0 = (ctrl[1:0] == 2'h0) & ctrl[4];
  assign pick1 = (ctrl[1:0] == 2'h1) & ctrl[5];

  always_comb begin
    if (swap) begin
      sel1_n = ~pick0;
      sel0_n = ~pick1;
      mot1_n = ~ctrl[4];
      mot0_n = ~ctrl[5];
    end else begin
      sel0_n = ~pick0;
      sel1_n = ~pick1;
      mot0_n = ~ctrl[4];
      mot1_n = ~ctrl[5];
    end
  end
endmodule // drive_decode
`default_nettype wire

// ---- verilog/edge_latch.sv ----
// sticky flag set by an input event, cleared by a read pulse
// assumes the event input is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module edge_latch (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // event and clear
  input  wire logic sig_in,
  input  wire logic rising,
  input  wire logic clear,
  // flag
  output logic      flag
);
  logic prev_reg;
  logic hit;

  assign hit = rising ? (sig_in & ~prev_reg) : (~sig_in & prev_reg);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sig_in;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag <= 1'b0;
    end else if (hit) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule // edge_latch
`default_nettype wire

// ---- verilog/floppy_drive_output_control.sv ----
// host-visible output control, tape and status-b registers of the floppy
// controller; assumes decoded i/o address with one-cycle rd/wr strobes
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_output_control (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // host i/o bus
  input  wire logic [15:0]               io_addr,
  input  wire logic                      io_rd,
  input  wire logic                      io_wr,
  input  wire logic [7:0]                io_wdata,
  output logic [7:0]                     io_rdata,
  output logic [7:0]                     io_rdata_oe,
  // configuration
  input  wire fdc_out_pkg::floppy_mode_t mode,
  input  wire logic                      swap_drives,
  input  wire logic                      alt_status_b,
  input  wire logic [7:0]                drive_type_config,
  // drive interface activity
  input  wire logic                      write_gate_out,
  input  wire logic                      read_data_in,
  input  wire logic                      write_data_out,
  // drive lines
  output logic                           drive_number_bit0_n,
  output logic                           drive_number_bit1_n,
  output logic                           motor_on0_out,
  output logic                           motor_on1_out,
  // controller core hooks
  output logic                           soft_rst_n,
  output logic                           dma_pin_enable,
  output logic                           dig_in_read
);
  import fdc_out_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] drive_output_control_reg;
  logic [1:0] tape_drive_assign_reg;
  logic [1:0] boot_drive_reg;
  logic       write_gate_out_flag;
  logic       rdata_flag;
  logic       wdata_flag;
  logic       sel0_n_c;
  logic       sel1_n_c;
  logic       mot0_n_c;
  logic       mot1_n_c;
  logic       rd_dig_in;
  logic [7:0] rdata_next;
  logic [7:0] oe_next;
  logic [1:0] type_id;

  function automatic logic [1:0] type_pick(input logic [7:0] cfg,
                                           input logic [1:0] idx);
    type_pick = cfg[{idx, 1'b0} +: 2];
  endfunction

  assign rd_dig_in = io_rd && (io_addr == ADDR_DIG_IN);
  assign type_id   = type_pick(drive_type_config,
                               drive_output_control_reg[1:0]);

  // soft reset bit only gates the core; register keeps its contents
  always_ff @(posedge clk) begin
    if (!nrst) begin
      drive_output_control_reg <= OUT_CTRL_RESET;
    end else if (io_wr && io_addr == ADDR_OUT_CTRL) begin
      drive_output_control_reg <= io_wdata;
    end
  end

  // tape register is not touched by the soft reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tape_drive_assign_reg <= TAPE_RESET;
      boot_drive_reg        <= BOOT_RESET;
    end else if (io_wr && io_addr == ADDR_TAPE) begin
      tape_drive_assign_reg <= io_wdata[1:0];
      if (mode == MODE_ENHANCED2) begin
        boot_drive_reg <= io_wdata[3:2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // latched drive activity flags
  edge_latch u_write_gate_out (
    .clk    (clk),
    .nrst   (nrst),
    .sig_in (write_gate_out),
    .rising (1'b1),
    .clear  (rd_dig_in),
    .flag   (write_gate_out_flag)
  );
  edge_latch u_rdata (
    .clk    (clk),
    .nrst   (nrst),
    .sig_in (read_data_in),
    .rising (1'b0),
    .clear  (rd_dig_in),
    .flag   (rdata_flag)
  );
  edge_latch u_wdata (
    .clk    (clk),
    .nrst   (nrst),
    .sig_in (write_data_out),
    .rising (1'b0),
    .clear  (rd_dig_in),
    .flag   (wdata_flag)
  );

  drive_decode u_decode (
    .ctrl   (drive_output_control_reg),
    .swap   (swap_drives),
    .sel0_n (sel0_n_c),
    .sel1_n (sel1_n_c),
    .mot0_n (mot0_n_c),
    .mot1_n (mot1_n_c)
  );

  //////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      drive_number_bit0_n  <= 1'b1;
      drive_number_bit1_n  <= 1'b1;
      motor_on0_out <= 1'b1;
      motor_on1_out <= 1'b1;
    end else begin
      drive_number_bit0_n  <= sel0_n_c;
      drive_number_bit1_n  <= sel1_n_c;
      motor_on0_out <= mot0_n_c;
      motor_on1_out <= mot1_n_c;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      soft_rst_n     <= 1'b0;
      // mode b keeps the dma/irq pins enabled right through reset
      dma_pin_enable <= (mode != MODE_COMPAT_A);
      dig_in_read    <= 1'b0;
    end else begin
      soft_rst_n     <= drive_output_control_reg[BIT_RST];
      dma_pin_enable <= (mode != MODE_COMPAT_A) ||
                        drive_output_control_reg[BIT_DMA];
      dig_in_read    <= rd_dig_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_next = 8'h00;
    oe_next    = 8'h00;
    if (io_addr == ADDR_OUT_CTRL) begin
      rdata_next = drive_output_control_reg;
      oe_next    = 8'hff;
    end else if (io_addr == ADDR_TAPE) begin
      if (mode == MODE_ENHANCED2) begin
        rdata_next = {2'h0, type_id, boot_drive_reg,
                      tape_drive_assign_reg};
        oe_next    = 8'hff;
      end else begin
        rdata_next = {6'h00, tape_drive_assign_reg};
        oe_next    = 8'h03;
      end
    end else if (io_addr == ADDR_STATUS_B) begin
      oe_next = 8'hff;
      if (alt_status_b) begin
        rdata_next = {1'b1, sel1_n_c, sel0_n_c, wdata_flag, rdata_flag,
                      write_gate_out_flag, 2'h3};
      end else begin
        rdata_next = {2'h3, drive_output_control_reg[0], 1'b0, 1'b0,
                      write_gate_out, drive_output_control_reg[5:4]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      io_rdata    <= 8'h00;
      io_rdata_oe <= 8'h00;
    end else if (io_rd) begin
      io_rdata    <= rdata_next;
      io_rdata_oe <= oe_next;
    end else begin
      io_rdata_oe <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence dir_read_s;
    io_rd && io_addr == ADDR_DIG_IN;
  endsequence

  primary_ones_a: assert property (@(posedge clk) disable iff (!nrst)
    io_rd && io_addr == ADDR_STATUS_B && !alt_status_b
    |=> io_rdata[7:6] == 2'h3)
    else $error("status b top bits not one");
  write_gate_out_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(write_gate_out) |=> write_gate_out_flag)
    else $error("write gate flag not set");
  rdata_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    dir_read_s and !$fell(read_data_in) |=> !rdata_flag)
    else $error("read flag not cleared");
  wdata_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(write_data_out) |=> wdata_flag)
    else $error("write data flag not set");
  ctrl_write_a: assert property (@(posedge clk) disable iff (!nrst)
    io_wr && io_addr == ADDR_OUT_CTRL
    |=> drive_output_control_reg == $past(io_wdata))
    else $error("output control write lost");
  soft_rst_a: assert property (@(posedge clk) disable iff (!nrst)
    io_wr && io_addr == ADDR_OUT_CTRL && !io_wdata[BIT_RST]
    |=> ##1 !soft_rst_n)
    else $error("soft reset not issued");
  one_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    !(!drive_number_bit0_n && !drive_number_bit1_n))
    else $error("two drives selected");
  dma_modeb_a: assert property (@(posedge clk) disable iff (!nrst)
    mode == MODE_COMPAT_B [*2] |-> dma_pin_enable)
    else $error("dma pins off in mode b");
  motor0_a: assert property (@(posedge clk) disable iff (!nrst)
    !swap_drives && $stable(swap_drives)
    |-> motor_on0_out == !$past(drive_output_control_reg[BIT_MOT0]))
    else $error("motor 0 mismatch");
endmodule // floppy_drive_output_control
`default_nettype wire
